// File: hdl/tape_punch_pkg.sv
// tape punch interface: shared constants and types
// assumes a single 50 MHz clock and synchronous active-high reset
package tape_punch_pkg;
    // ==========================================
    // register addresses on the serial i/o bus
    localparam logic [15:0] STATUS_ADDR = 16'hFFEC;
    localparam logic [15:0] CHAR_ADDR = 16'hFFEE;
    // status bit positions
    localparam int DONE_BIT = 7;
    localparam int ERR_BIT = 6;
    localparam int UNAV_BIT = 5;
    localparam int IEN_BIT = 0;
    // values after reset
    localparam logic DONE_RST = 1'b1;
    localparam logic IEN_RST = 1'b0;
    // interrupt poll position and transfer vector
    localparam logic [3:0] POLL_POS = 4'h2;
    localparam logic [7:0] VECTOR_ADDR = 8'hF0;  // 240 decimal
    // timing
    localparam int CLOCK_HZ = 50000000;
    localparam real LATENCY_MS = 13.3;
    localparam int LATENCY_CYC = int'(LATENCY_MS * CLOCK_HZ / 1000.0);
    // fifo shape
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 4;
    // punch sequencer states
    typedef enum logic [1:0] {IDLE, START, WAIT_CYCLE} punch_state_t;
endpackage : tape_punch_pkg

// File: hdl/char_stream_if.sv
// char_stream_if: valid/ready character stream between internal modules
// assumes both ends on the same clock
`timescale 1ns/100ps
`default_nettype none
interface char_stream_if;
    logic valid;       // word offered
    logic ready;       // word accepted
    logic [7:0] data;  // character
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : char_stream_if
`default_nettype wire

// File: hdl/char_fifo.sv
// char_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic srst,
    char_stream_if.snk inS,
    char_stream_if.src outS
);
    // ==========================================
    // storage and pointers
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // word array
    logic [AW-1:0] wrPtr_q;         // write index
    logic [AW-1:0] rdPtr_q;         // read index
    logic [AW:0] count_q;           // words held
    logic push;
    logic pop;

    // handshakes: honest full and empty
    assign inS.ready = (count_q != (AW+1)'(DEPTH));
    assign outS.valid = (count_q != '0);
    assign outS.data = mem[rdPtr_q];
    assign push = inS.valid && inS.ready;
    assign pop = outS.valid && outS.ready;

    // data write
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_q] <= inS.data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clock) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // never exceeds depth
    a_fifo_bound: assert property (@(posedge clock) disable iff (srst)
        count_q <= (AW+1)'(DEPTH))
        else $error("fifo occupancy above depth");
endmodule : char_fifo
`default_nettype wire

// File: hdl/tape_punch_interface.sv
// tape_punch_interface: paper tape punch port on the serial i/o bus
// assumes bus strobes are single-cycle, synchronous to clock;
// the mechanism returns a one-cycle done pulse and static levels
`timescale 1ns/100ps
`default_nettype none
module tape_punch_interface (
    input wire logic clock,
    input wire logic srst,
    // serial i/o bus register port
    input wire logic [15:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic [7:0] busWrData,
    output logic [7:0] busRdData,
    output logic busAck,
    // interrupt poll
    input wire logic [3:0] pollPos,
    input wire logic pollStrobe,
    output logic intRequest,
    output logic pollHit,
    output logic [7:0] pollVector,
    // punch mechanism
    output logic punchStart,
    output logic [7:0] punchChar,
    input wire logic punchCycleDone,
    input wire logic punchOnline,
    input wire logic punchFeedFault,
    input wire logic punchLoadSwitch
);
    // ==========================================
    // decode and conditions
    // the bus decode is purely combinational; the status
    // conditions come straight from mechanism levels so that
    // a status read always shows the live state of the punch
    logic statusSel;        // status address hit
    logic charSel;          // buffer address hit
    logic unavail;          // punch off line or absent
    logic errFlag;          // feed fault or load position
    logic blocked;          // punch may not run
    logic done_q;           // completion flag
    logic intEn_q;          // interrupt enable
    logic intReq_q;         // pending request
    logic unavPrev_q;       // last cycle flags, for edges
    logic errPrev_q;
    logic donePrev_q;
    logic busy_q;           // a cycle is in flight
    logic [7:0] rdData_q;   // registered read data
    logic ack_q;
    tape_punch_pkg::punch_state_t state_q;
    logic rise;

    char_stream_if toFifo ();
    char_stream_if fromFifo ();

    assign statusSel = (busAddr == tape_punch_pkg::STATUS_ADDR);
    assign charSel = (busAddr == tape_punch_pkg::CHAR_ADDR);
    assign unavail = !punchOnline;
    assign errFlag = punchFeedFault || punchLoadSwitch;
    assign blocked = unavail || errFlag;

    // ==========================================
    // character buffer path
    // a write is judged against the punch state in the same cycle;
    // a dropped write leaves the fifo and the done flag untouched
    // a write into a full fifo is lost without warning, so the host
    // must keep to one character per completion as the status shows
    // writes enter the fifo only when the punch can run
    assign toFifo.valid = busWrite && charSel && !blocked;
    assign toFifo.data = busWrData;

    // four-deep queue absorbs a short burst of writes; the
    // sequencer drains it one character per punch cycle
    char_fifo #(
        .WIDTH(tape_punch_pkg::FIFO_WIDTH),
        .DEPTH(tape_punch_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .srst(srst),
        .inS(toFifo),
        .outS(fromFifo)
    );

    // sequencer pops one word per punch cycle
    assign fromFifo.ready = (state_q == tape_punch_pkg::IDLE) && !blocked;

    // ==========================================
    // punch sequencer
    // one character per start pulse; the next start waits for the
    // mechanism's cycle-complete pulse or an abandon, so starts overlap only after an abandon
    // a fault or loss of the unit mid-cycle abandons the cycle,
    // since the mechanism cannot be trusted to answer any more
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= tape_punch_pkg::IDLE;
            punchStart <= 1'b0;
            punchChar <= 8'h00;
            busy_q <= 1'b0;
        end else begin
            punchStart <= 1'b0;
            case (state_q)
                tape_punch_pkg::IDLE: begin
                    // take next character when allowed
                    if (fromFifo.valid && fromFifo.ready) begin
                        punchChar <= fromFifo.data;
                        punchStart <= 1'b1;
                        busy_q <= 1'b1;
                        state_q <= tape_punch_pkg::WAIT_CYCLE;
                    end
                end
                tape_punch_pkg::WAIT_CYCLE: begin
                    // wait for the mechanism, or abandon on fault
                    if (punchCycleDone || blocked) begin
                        busy_q <= 1'b0;
                        state_q <= tape_punch_pkg::IDLE;
                    end
                end
                default: begin
                    state_q <= tape_punch_pkg::IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // completion flag
    // the write clear has priority over the cycle-end set: a host
    // that reloads in the very cycle of completion must see done low
    // done rises only once the queue is empty, so a queued burst
    // gives one completion at its end
    always_ff @(posedge clock) begin
        if (srst) begin
            done_q <= tape_punch_pkg::DONE_RST;
        end else if (busWrite && charSel && !blocked) begin
            done_q <= 1'b0;
        end else if (state_q == tape_punch_pkg::WAIT_CYCLE && punchCycleDone
                     && !blocked && !fromFifo.valid) begin
            done_q <= 1'b1;
        end
    end

    // interrupt enable, bit 0 only writable
    // the other status bits are read only or unused, so a status
    // write touches the enable alone; bits 7..1 of the data are ignored
    always_ff @(posedge clock) begin
        if (srst) begin
            intEn_q <= tape_punch_pkg::IEN_RST;
        end else if (busWrite && statusSel) begin
            intEn_q <= busWrData[tape_punch_pkg::IEN_BIT];
        end
    end

    // ==========================================
    // interrupt request: set wins over read clear
    // a flag edge is found by comparing with last cycle's copy; the
    // copy of done resets to one so that reset itself raises no edge
    // when an edge and a status read meet in one cycle the edge wins,
    // so no completion is lost to a read that did not see it
    assign rise = (done_q && !donePrev_q) || (errFlag && !errPrev_q)
                  || (unavail && !unavPrev_q);
    always_ff @(posedge clock) begin
        if (srst) begin
            intReq_q <= 1'b0;
            donePrev_q <= tape_punch_pkg::DONE_RST;
            errPrev_q <= 1'b0;
            unavPrev_q <= 1'b0;
        end else begin
            donePrev_q <= done_q;
            errPrev_q <= errFlag;
            unavPrev_q <= unavail;
            if (intEn_q && rise) begin
                intReq_q <= 1'b1;
            end else if (busRead && statusSel) begin
                intReq_q <= 1'b0;
            end
        end
    end
    assign intRequest = intReq_q;

    // poll answer at fixed position
    // the vector is constant; the poll logic outside picks the hit
    // only when this port has a request pending
    assign pollHit = pollStrobe && intReq_q
                     && (pollPos == tape_punch_pkg::POLL_POS);
    assign pollVector = tape_punch_pkg::VECTOR_ADDR;

    // ==========================================
    // register read port, one cycle latency
    // every strobe is acknowledged one cycle later, mapped or not;
    // read data stays zero except in the cycle after a status read
    always_ff @(posedge clock) begin
        if (srst) begin
            rdData_q <= 8'h00;
            ack_q <= 1'b0;
        end else begin
            ack_q <= busRead || busWrite;
            rdData_q <= 8'h00;
            if (busRead && statusSel) begin
                // bits 4..1 stay zero
                rdData_q <= {done_q, errFlag, unavail, 4'h0, intEn_q};
            end
        end
    end
    assign busRdData = rdData_q;
    assign busAck = ack_q;

    // ==========================================
    // checks
    // all checks run on the one clock and, except a_reset_done, are idle during reset;
    // each guards one promise made to the host or the mechanism

    // a new cycle only begins when the punch was free to run
    a_start_blocked: assert property (@(posedge clock) disable iff (srst)
        $rose(busy_q) |-> $past(!blocked))
        else $error("punch started while blocked");
    // an accepted write lowers done at once
    a_write_clears: assert property (@(posedge clock) disable iff (srst)
        (busWrite && charSel && !blocked) |=> !done_q)
        else $error("done not cleared by write");
    // the end of the last queued cycle raises done
    a_done_sets: assert property (@(posedge clock) disable iff (srst)
        (state_q == tape_punch_pkg::WAIT_CYCLE && punchCycleDone && !blocked
         && !fromFifo.valid && !(busWrite && charSel)) |=> done_q)
        else $error("done not set by cycle end");
    // a blocked write never reaches the mechanism
    a_ignored_write: assert property (@(posedge clock) disable iff (srst)
        (busWrite && charSel && blocked && !fromFifo.valid && !busy_q)
        |=> !punchStart)
        else $error("blocked write reached punch");
    // an enabled flag edge raises the request
    a_irq_set: assert property (@(posedge clock) disable iff (srst)
        (intEn_q && rise) |=> intRequest)
        else $error("interrupt not raised");
    // a status read drops the request
    a_irq_clear: assert property (@(posedge clock) disable iff (srst)
        (busRead && statusSel && !(intEn_q && rise)) |=> !intRequest)
        else $error("status read left request");
    // unused bits read zero
    a_status_bits: assert property (@(posedge clock) disable iff (srst)
        $past(busRead && statusSel) |-> busRdData[4:1] == 4'h0)
        else $error("unused status bits nonzero");
    // error and unavailable bits follow the mechanism
    a_status_flags: assert property (@(posedge clock) disable iff (srst)
        $past(busRead && statusSel)
        |-> busRdData[5] == $past(unavail) && busRdData[6] == $past(errFlag))
        else $error("status flags wrong");
    // a status write loads the enable
    a_enable_wr: assert property (@(posedge clock) disable iff (srst)
        (busWrite && statusSel) |=> intEn_q == $past(busWrData[0]))
        else $error("enable not written");
    // the poll answer carries the fixed position and vector
    a_poll_answer: assert property (@(posedge clock) disable iff (srst)
        pollHit |-> pollPos == 4'h2 && pollVector == 8'hF0)
        else $error("poll answered wrongly");
    // reset leaves done high and interrupts off
    a_reset_done: assert property (@(posedge clock)
        $past(srst) |-> done_q && !intEn_q)
        else $error("reset values wrong");

    // no start follows a blocked cycle
    a_no_start_blocked: assert property (@(posedge clock) disable iff (srst)
        blocked |=> !punchStart)
        else $error("start issued while blocked");
    // done cannot rise while the punch is blocked
    a_done_held_blocked: assert property (@(posedge clock) disable iff (srst)
        (blocked && !done_q) |=> !done_q)
        else $error("done set while blocked");
    // a cycle in flight is abandoned on a fault
    a_abort_fault: assert property (@(posedge clock) disable iff (srst)
        (state_q == tape_punch_pkg::WAIT_CYCLE && blocked) |=> state_q == tape_punch_pkg::IDLE)
        else $error("cycle not abandoned");
    // a dropped write leaves done as it was
    a_drop_keeps_done: assert property (@(posedge clock) disable iff (srst)
        (busWrite && charSel && blocked) |=> done_q == $past(done_q))
        else $error("dropped write moved done");

    // the start pulse lasts one cycle
    a_start_pulse: assert property (@(posedge clock) disable iff (srst)
        punchStart |=> !punchStart)
        else $error("start pulse too long");
    // the character changes only with a start
    a_char_held: assert property (@(posedge clock) disable iff (srst)
        !punchStart |-> $stable(punchChar))
        else $error("character moved without start");
    // the start carries the head of the queue
    a_start_char: assert property (@(posedge clock) disable iff (srst)
        punchStart |-> punchChar == $past(fromFifo.data))
        else $error("wrong character launched");

    // the request holds until a status read
    a_irq_hold: assert property (@(posedge clock) disable iff (srst)
        (intRequest && !(busRead && statusSel)) |=> intRequest)
        else $error("request lost without read");
    // the request rises only on an enabled edge
    a_irq_quiet: assert property (@(posedge clock) disable iff (srst)
        (!intRequest && !(intEn_q && rise)) |=> !intRequest)
        else $error("request raised without cause");
    // another position is never answered
    a_poll_other: assert property (@(posedge clock) disable iff (srst)
        (pollPos != tape_punch_pkg::POLL_POS) |-> !pollHit)
        else $error("poll answered at wrong position");
    // read data is zero outside a status read answer
    a_rd_idle: assert property (@(posedge clock) disable iff (srst)
        !$past(busRead && statusSel) |-> busRdData == 8'h00)
        else $error("read data not idle");
    // every strobe is answered one cycle later
    a_bus_ack: assert property (@(posedge clock) disable iff (srst)
        (busRead || busWrite) |=> busAck)
        else $error("strobe not acknowledged");
    // no answer without a strobe
    a_ack_cause: assert property (@(posedge clock) disable iff (srst)
        busAck |-> $past(busRead || busWrite))
        else $error("acknowledge without strobe");

    c_punch: cover property (@(posedge clock) disable iff (srst)
        punchStart ##[1:20] punchCycleDone);
    c_irq: cover property (@(posedge clock) disable iff (srst)
        $rose(intRequest));
    c_drop: cover property (@(posedge clock) disable iff (srst)
        busWrite && charSel && blocked);
    c_full: cover property (@(posedge clock) disable iff (srst)
        !toFifo.ready);
    c_abort: cover property (@(posedge clock) disable iff (srst)
        state_q == tape_punch_pkg::WAIT_CYCLE && blocked);
endmodule : tape_punch_interface
`default_nettype wire

// File: verif/punch_mech_model.sv
// punch_mech_model: behavioural punch mechanism on the far side of the port
// assumes one clock shared with the interface, start arrives as a pulse
`timescale 1ns/100ps
`default_nettype none
module punch_mech_model #(
    parameter int CYCLES = 12
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic punchStart,
    output logic punchCycleDone
);
    // ==========================================
    // punch cycle timer
    int count;  // cycles left in the current punch
    // one done pulse a fixed time after the latest start; a start mid-count restarts the timer
    always_ff @(posedge clock) begin
        if (srst) begin
            count <= 0;
            punchCycleDone <= 1'b0;
        end else begin
            punchCycleDone <= (count == 1);
            if (punchStart) begin
                count <= CYCLES;
            end else if (count != 0) begin
                count <= count - 1;
            end
        end
    end
endmodule : punch_mech_model
`default_nettype wire

// File: verif/tb_tape_punch_interface.sv
// tb_tape_punch_interface: self-checking bench for the punch port
// assumes the package, fifo, interface and mechanism model compile first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_tape_punch_interface;
    // ==========================================
    // stimulus and observed signals
    logic clock = 1'b0, srst = 1'b1, busRead = 1'b0, busWrite = 1'b0;
    logic [15:0] busAddr = 16'h0000;
    logic [7:0] busWrData = 8'h00, busRdData, pollVector, punchChar, lastChar;
    logic [3:0] pollPos = 4'h0;
    logic pollStrobe = 1'b0, busAck, intRequest, pollHit, punchStart, punchCycleDone;
    logic punchOnline = 1'b1, punchFeedFault = 1'b0, punchLoadSwitch = 1'b0;
    int miscompares = 0, testsRun = 0, cycles = 0, startCount = 0;
    localparam logic [15:0] STAT = tape_punch_pkg::STATUS_ADDR;
    localparam logic [15:0] CHAR = tape_punch_pkg::CHAR_ADDR;
    tape_punch_interface dut (.clock(clock), .srst(srst), .busAddr(busAddr),
        .busRead(busRead), .busWrite(busWrite), .busWrData(busWrData),
        .busRdData(busRdData), .busAck(busAck), .pollPos(pollPos),
        .pollStrobe(pollStrobe), .intRequest(intRequest), .pollHit(pollHit),
        .pollVector(pollVector), .punchStart(punchStart), .punchChar(punchChar),
        .punchCycleDone(punchCycleDone), .punchOnline(punchOnline),
        .punchFeedFault(punchFeedFault), .punchLoadSwitch(punchLoadSwitch));
    punch_mech_model mech (.clock(clock), .srst(srst), .punchStart(punchStart),
        .punchCycleDone(punchCycleDone));
    // ==========================================
    // clock, start monitor, hang guard
    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (punchStart === 1'b1) begin
            startCount++;
            lastChar = punchChar;
        end
        if (cycles == 5000) begin
            miscompares++;
            closeOut();
        end
    end
    // ==========================================
    // bus access: strobe for one cycle, answer one cycle later
    task automatic busCycle(input logic rd, input logic [15:0] a, input logic [7:0] d,
            output logic [7:0] q);
        busRead = rd;
        busWrite = ~rd;
        busAddr = a;
        busWrData = d;
        @(negedge clock);
        busRead = 1'b0;
        busWrite = 1'b0;
        q = busRdData;
        `CHK(busAck, 1'b1)
    endtask : busCycle
    task automatic readCheck(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] q;
        busCycle(1'b1, a, 8'h00, q);
        `CHK(q, exp)
    endtask : readCheck
    task automatic writeReg(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        busCycle(1'b0, a, d, q);
    endtask : writeReg
    // ==========================================
    // scenarios
    task automatic testReset();
        `CHK(intRequest, 1'b0)
        readCheck(STAT, 8'h80);
        writeReg(STAT, 8'hFF);
        readCheck(STAT, 8'h81);
        readCheck(16'hFFE0, 8'h00);
        $display("test reset/status done");
    endtask : testReset
    task automatic testPunch();
        int n;
        n = startCount;
        readCheck(STAT, 8'h81);
        writeReg(CHAR, 8'hA5);
        readCheck(STAT, 8'h01);
        for (int i = 0; i < 40 && intRequest !== 1'b1; i++) @(negedge clock);
        `CHK(startCount, n + 1)
        `CHK(lastChar, 8'hA5)
        `CHK(intRequest, 1'b1)
        pollPos = 4'h2;
        pollStrobe = 1'b1;
        #1 `CHK(pollHit, 1'b1)
        `CHK(pollVector, 8'hF0)
        pollPos = 4'h3;
        #1 `CHK(pollHit, 1'b0)
        pollStrobe = 1'b0;
        @(negedge clock);
        readCheck(STAT, 8'h81);
        `CHK(intRequest, 1'b0)
        writeReg(CHAR, 8'h5A);
        for (int i = 0; i < 40 && intRequest !== 1'b1; i++) @(negedge clock);
        `CHK(lastChar, 8'h5A)
        `CHK(startCount, n + 2)
        readCheck(STAT, 8'h81);
        $display("test punch cycle done");
    endtask : testPunch
    task automatic testBlocked();
        int n;
        n = startCount;
        punchOnline = 1'b0;
        repeat (3) @(negedge clock);
        `CHK(intRequest, 1'b1)
        readCheck(STAT, 8'hA1);
        writeReg(CHAR, 8'h3C);
        repeat (30) @(negedge clock);
        `CHK(startCount, n)
        readCheck(STAT, 8'hA1);
        punchOnline = 1'b1;
        punchFeedFault = 1'b1;
        repeat (3) @(negedge clock);
        readCheck(STAT, 8'hC1);
        punchFeedFault = 1'b0;
        punchLoadSwitch = 1'b1;
        repeat (3) @(negedge clock);
        readCheck(STAT, 8'hC1);
        punchLoadSwitch = 1'b0;
        repeat (30) @(negedge clock);
        `CHK(startCount, n)
        $display("test blocked punch done");
    endtask : testBlocked
    // ==========================================
    // verdict
    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : closeOut
    initial begin
        repeat (16) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        testReset();
        testPunch();
        testBlocked();
        closeOut();
    end
endmodule : tb_tape_punch_interface
`default_nettype wire
